// [common/gpt_pkg.sv]
// Shared constants and types for the timer and free-running counter
package gpt_pkg;

  localparam int HALF_W = 16;
  localparam int FULL_W = 32;

  // Register byte offsets on the host bus
  localparam logic [7:0] TIMER_CONFIG_OFS = 8'h8c;
  localparam logic [7:0] TIMER_COUNT_OFS = 8'h90;
  localparam logic [7:0] FREE_RUN_OFS = 8'h9c;

  // Address bit that picks the upper half-word
  localparam int HALF_SEL_BIT = 1;

  // Run-enable sits at bit 29 of the config word, bit 13 of its top half
  localparam int RUN_EN_BIT = 29;
  localparam int RUN_EN_HI_BIT = RUN_EN_BIT - HALF_W;

  localparam logic [HALF_W-1:0] PRELOAD_RST = 16'hffff;
  localparam logic [HALF_W-1:0] COUNT_RST = 16'hffff;
  localparam logic [FULL_W-1:0] FREE_RUN_RST = 32'h0;
  localparam logic [HALF_W-1:0] RESERVED_READ = 16'h0;

  // Timing at the 10 MHz core clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLEAR_TIME_NS = 160;
  localparam int CLEAR_CYCLES_RAW = CLEAR_TIME_NS / CLK_PERIOD_NS;
  localparam int CLEAR_CYCLES = (CLEAR_CYCLES_RAW < 1) ? 1 : CLEAR_CYCLES_RAW;
  localparam int TICK_TIME_NS = 100000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

  // Half-word capture state of the free-running counter read
  typedef enum logic [2:0] {
    LATCH_IDLE = 3'b001,
    LATCH_HI_DUE = 3'b010,
    LATCH_LO_DUE = 3'b100
  } latch_state_t;

  // Word offset of a byte address, half select stripped
  function automatic logic [7:0] wordOfs(input logic [7:0] addr);
    return {addr[7:2], 2'b00};
  endfunction

endpackage

// [src/gp_countdown.sv]
// Down-counting general purpose timer with tick prescaler and reload
module gp_countdown
  import gpt_pkg::*;
#(
  parameter int WIDTH = HALF_W,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic runEn,
  input wire logic [WIDTH-1:0] preload,
  output logic [WIDTH-1:0] count,
  output logic expire
);

  localparam int TW = $clog2(TICK_CYCLES) + 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1 || WIDTH < 1) begin : gen_chk
    $error("gp_countdown: TICK_CYCLES and WIDTH must be at least 1");
  end

  logic [TW-1:0] tickCnt_r;
  logic [WIDTH-1:0] count_r;
  logic runDly_r;
  logic expire_r;
  logic tick;

  assign tick = runEn && runDly_r && (tickCnt_r == TICK_LAST);

  // Prescaler restarts while halted
  always_ff @(posedge clk) begin
    if (!rst_n || !runEn || tick) begin
      tickCnt_r <= '0;
    end else begin
      tickCnt_r <= TW'(tickCnt_r + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runDly_r <= 1'b0;
    end else begin
      runDly_r <= runEn;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= {WIDTH{1'b1}};
    end else if (runEn && !runDly_r) begin
      count_r <= preload;
    end else if (tick) begin
      if (count_r == '0) begin
        count_r <= preload;
      end else begin
        count_r <= WIDTH'(count_r - 1'b1);
      end
    end
  end

  // Expiry pulse drives the host interrupt path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expire_r <= 1'b0;
    end else begin
      expire_r <= tick && (count_r == '0);
    end
  end

  assign count = count_r;
  assign expire = expire_r;

endmodule

// [src/free_run_latch.sv]
// Free-running counter with a capture register for split reads
module free_run_latch
  import gpt_pkg::*;
#(
  parameter int WIDTH = FULL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic capture,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH-1:0] held
);

  if (WIDTH < 2 || WIDTH % 2 != 0) begin : gen_chk
    $error("free_run_latch: WIDTH must be even and at least 2");
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] held_r;

  // No power state gates this counter; it rolls over naturally
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= WIDTH'(count_r + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_r <= '0;
    end else if (capture) begin
      held_r <= count_r;
    end
  end

  assign count = count_r;
  assign held = held_r;

endmodule

// [src/gp_timer_and_free_run_counter.sv]
// Timer and free-running counter registers behind the 16-bit host bus
//
// Operation
// - Writing one to run-enable starts the general purpose timer.
// - With run-enable zero the timer is halted and its count stands.
// - Run-enable falling from one to zero forces the preload to all ones.
// - Timer loads from a 16-bit read-write preload, reset value all ones.
// - Timer expiry gives periodic host interrupt events set by the preload.
// - Current count register returns the count in bits 15-0, reset ones.
// - Free-running counter is 32 bits, starts at zero, counts every cycle.
// - At its maximum the free-running counter wraps to zero and goes on.
// - First half-word read captures the count; a second read of the other half returns its match.
// - After reset the free-running counter reads zero within 160 ns.
// - No power state stops the free-running counter.
module gp_timer_and_free_run_counter
  import gpt_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] hostAddr,
  input wire logic hostRd,
  input wire logic hostWr,
  input wire logic [HALF_W-1:0] hostWrData,
  output logic [HALF_W-1:0] hostRdData,
  output logic hostRdValid,
  input wire logic timerFlagClr,
  output logic timerFlag,
  output logic timerEvent
);

  if (TICK_CYCLES < 1) begin : gen_chk
    $error("TICK_CYCLES must be at least 1");
  end

  logic [7:0] accWord;
  logic hiHalf;
  logic cfgWrLo;
  logic cfgWrHi;
  logic frRead;

  logic runEn_r;
  logic runEn_nxt;
  logic [HALF_W-1:0] preload_r;
  logic timerFlag_r;
  logic [HALF_W-1:0] hostRdData_r;
  logic [HALF_W-1:0] hostRdData_nxt;
  logic hostRdValid_r;

  latch_state_t latchState_r;
  latch_state_t latchState_nxt;
  logic capture;

  logic [HALF_W-1:0] timerCount;
  logic timerExpire;
  logic [FULL_W-1:0] freeCount;
  logic [FULL_W-1:0] heldCount;

  // Address decode
  assign accWord = wordOfs(hostAddr);
  assign hiHalf = hostAddr[HALF_SEL_BIT];
  assign cfgWrLo = hostWr && (accWord == TIMER_CONFIG_OFS) && !hiHalf;
  assign cfgWrHi = hostWr && (accWord == TIMER_CONFIG_OFS) && hiHalf;
  assign frRead = hostRd && (accWord == FREE_RUN_OFS);

  assign runEn_nxt = cfgWrHi ? hostWrData[RUN_EN_HI_BIT] : runEn_r;

  // Run-enable bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runEn_r <= 1'b0;
    end else begin
      runEn_r <= runEn_nxt;
    end
  end

  // Preload field
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preload_r <= PRELOAD_RST;
    end else if (runEn_r && !runEn_nxt) begin
      preload_r <= PRELOAD_RST;
    end else if (cfgWrLo) begin
      preload_r <= hostWrData;
    end
  end

  gp_countdown #(
    .WIDTH(HALF_W),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .runEn(runEn_r),
    .preload(preload_r),
    .count(timerCount),
    .expire(timerExpire)
  );

  // Sticky expiry flag; a new expiry beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timerFlag_r <= 1'b0;
    end else if (timerExpire) begin
      timerFlag_r <= 1'b1;
    end else if (timerFlagClr) begin
      timerFlag_r <= 1'b0;
    end
  end

  assign timerFlag = timerFlag_r;
  assign timerEvent = timerExpire;

  // Half-word capture sequencing for the free-running counter
  always_comb begin
    latchState_nxt = latchState_r;
    capture = 1'b0;
    if (frRead) begin
      case (latchState_r)
        LATCH_IDLE: begin
          capture = 1'b1;
          latchState_nxt = hiHalf ? LATCH_LO_DUE : LATCH_HI_DUE;
        end
        LATCH_HI_DUE: begin
          if (hiHalf) begin
            latchState_nxt = LATCH_IDLE;
          end else begin
            capture = 1'b1;
          end
        end
        LATCH_LO_DUE: begin
          if (!hiHalf) begin
            latchState_nxt = LATCH_IDLE;
          end else begin
            capture = 1'b1;
          end
        end
        default: begin
          latchState_nxt = LATCH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latchState_r <= LATCH_IDLE;
    end else begin
      latchState_r <= latchState_nxt;
    end
  end

  free_run_latch #(
    .WIDTH(FULL_W)
  ) u_free_run (
    .clk(clk),
    .rst_n(rst_n),
    .capture(capture),
    .count(freeCount),
    .held(heldCount)
  );

  // Read data mux; unmapped and reserved bits read zero
  always_comb begin
    hostRdData_nxt = RESERVED_READ;
    case (accWord)
      TIMER_CONFIG_OFS: begin
        if (hiHalf) begin
          hostRdData_nxt[RUN_EN_HI_BIT] = runEn_r;
        end else begin
          hostRdData_nxt = preload_r;
        end
      end
      TIMER_COUNT_OFS: begin
        if (!hiHalf) begin
          hostRdData_nxt = timerCount;
        end
      end
      FREE_RUN_OFS: begin
        if (capture) begin
          hostRdData_nxt = hiHalf ? freeCount[FULL_W-1:HALF_W]
                                  : freeCount[HALF_W-1:0];
        end else begin
          hostRdData_nxt = hiHalf ? heldCount[FULL_W-1:HALF_W]
                                  : heldCount[HALF_W-1:0];
        end
      end
      default: begin
        hostRdData_nxt = RESERVED_READ;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hostRdData_r <= RESERVED_READ;
      hostRdValid_r <= 1'b0;
    end else begin
      hostRdValid_r <= hostRd;
      if (hostRd) begin
        hostRdData_r <= hostRdData_nxt;
      end
    end
  end

  assign hostRdData = hostRdData_r;
  assign hostRdValid = hostRdValid_r;

  // Checks
  localparam int CLR_DLY = CLEAR_CYCLES;

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  sequence runStartS;
    !runEn_r ##1 runEn_r;
  endsequence

  sequence haltedS;
    !runEn_r ##1 !runEn_r;
  endsequence

  sequence loFirstS;
    frRead && !hiHalf && latchState_r == LATCH_IDLE;
  endsequence

  sequence hiSecondS;
    frRead && hiHalf && latchState_r == LATCH_HI_DUE;
  endsequence

  timer_start_a: assert property (
    runStartS |=> timerCount == $past(preload_r))
    else $error("timer did not load preload on start");

  halt_hold_a: assert property (
    haltedS ##1 !runEn_r |-> $stable(timerCount) && !timerExpire)
    else $error("halted timer count moved");

  preload_force_a: assert property (
    $fell(runEn_r) |-> preload_r == PRELOAD_RST)
    else $error("preload not forced to ones on halt");

  preload_write_a: assert property (
    cfgWrLo && !(runEn_r && !runEn_nxt) |=> preload_r == $past(hostWrData))
    else $error("preload write lost");

  expire_reload_a: assert property (
    timerExpire |-> timerCount == $past(preload_r) ##1 timerFlag_r)
    else $error("expiry without reload or flag");

  flag_sticky_a: assert property (
    timerFlag_r && !timerFlagClr |=> timerFlag_r)
    else $error("timer flag dropped without clear");

  count_read_a: assert property (
    hostRd && accWord == TIMER_COUNT_OFS |=>
      hostRdValid && hostRdData == ($past(hiHalf) ? RESERVED_READ
                                                  : $past(timerCount)))
    else $error("current count read wrong");

  free_inc_a: assert property (
    $past(rst_n) |-> freeCount == FULL_W'($past(freeCount) + 1'b1))
    else $error("free-running counter did not advance by one");

  free_wrap_a: assert property (
    freeCount == '1 |=> freeCount == FREE_RUN_RST)
    else $error("free-running counter did not wrap to zero");

  capture_take_a: assert property (
    loFirstS |=> heldCount == $past(freeCount) &&
      hostRdData == $past(freeCount[HALF_W-1:0]))
    else $error("first half read did not capture count");

  pair_match_a: assert property (
    loFirstS ##1 (!frRead) [*1] ##1 hiSecondS |=>
      hostRdData == $past(heldCount[FULL_W-1:HALF_W]))
    else $error("second half does not match captured count");

  clear_time_a: assert property (
    disable iff (1'b0) !rst_n |-> ##CLR_DLY freeCount == FREE_RUN_RST)
    else $error("free-running counter not cleared after reset");

endmodule

// [verification/host_bus_model.sv]
// Host CPU model issuing half-word accesses on the register bus
module host_bus_model
  import gpt_pkg::*;
(
  input wire logic clk,
  output logic [7:0] hostAddr,
  output logic hostRd,
  output logic hostWr,
  output logic [HALF_W-1:0] hostWrData,
  input wire logic [HALF_W-1:0] hostRdData,
  input wire logic hostRdValid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    hostAddr = 8'h00;
    hostRd = 1'b0;
    hostWr = 1'b0;
    hostWrData = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [HALF_W-1:0] d);
    @(posedge clk);
    #1;
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'b1;
    @(posedge clk);
    #1;
    hostWr = 1'b0;
    // Released lines show the inverse, never a stale value
    hostAddr = ~a;
    hostWrData = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [HALF_W-1:0] d);
    @(posedge clk);
    #1;
    hostAddr = a;
    hostRd = 1'b1;
    @(posedge clk);
    #1;
    hostRd = 1'b0;
    hostAddr = ~a;
    d = (hostRdValid === 1'b1) ? hostRdData : 'x;
  endtask
endmodule

// [verification/gp_timer_and_free_run_counter_tb_top.sv]
// Self-checking bench for the timer and free-running counter
module gp_timer_and_free_run_counter_tb_top
  import gpt_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TICKS = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic timerFlagClr = 1'b0;
  logic [7:0] hostAddr;
  logic hostRd;
  logic hostWr;
  logic [HALF_W-1:0] hostWrData;
  logic [HALF_W-1:0] hostRdData;
  logic hostRdValid;
  logic timerFlag;
  logic timerEvent;
  logic [HALF_W-1:0] v;
  int nFail = 0;
  int totalChecks = 0;
  int n;

  always #50 clk = ~clk;

  gp_timer_and_free_run_counter #(.TICK_CYCLES(TICKS)) dut (
    .clk(clk), .rst_n(rst_n), .hostAddr(hostAddr), .hostRd(hostRd),
    .hostWr(hostWr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .timerFlagClr(timerFlagClr),
    .timerFlag(timerFlag), .timerEvent(timerEvent)
  );

  host_bus_model host (
    .clk(clk), .hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
    .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid)
  );

  task automatic check16(input string what, input logic [HALF_W-1:0] e,
                         input logic [HALF_W-1:0] g);
    totalChecks++;
    if (g !== e) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic checkBit(input string what, input logic e, input logic g);
    totalChecks++;
    if (g !== e) begin
      nFail++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask

  task automatic expectRd(input string what, input logic [7:0] a,
                          input logic [HALF_W-1:0] e);
    logic [HALF_W-1:0] d;
    host.rd(a, d);
    check16(what, e, d);
  endtask

  // Clocks until the next expiry pulse, bounded
  task automatic waitEvent(output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while (timerEvent !== 1'b1 && cyc < 200);
  endtask

  task automatic closeOut;
    $display("checks %0d, mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    nFail++;
    $display("unexpected run length: expected finish, seen timeout");
    closeOut;
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    host.rd(FREE_RUN_OFS, v);
    checkBit("free run after reset", 1'b1, v < 16'h0004);
    expectRd("preload reset", TIMER_CONFIG_OFS, PRELOAD_RST);
    expectRd("run enable reset", 8'h8e, 16'h0000);
    expectRd("count reset", TIMER_COUNT_OFS, COUNT_RST);
    expectRd("count upper", 8'h92, RESERVED_READ);
    host.wr(TIMER_COUNT_OFS, 16'h1234);
    expectRd("count after write", TIMER_COUNT_OFS, COUNT_RST);
    expectRd("unmapped", 8'h94, 16'h0000);
    host.rd(FREE_RUN_OFS, v);
    expectRd("free run step", FREE_RUN_OFS, v + 16'h0002);
    host.wr(TIMER_CONFIG_OFS, 16'h0003);
    expectRd("preload write", TIMER_CONFIG_OFS, 16'h0003);
    host.wr(8'h8e, 16'hffff);
    expectRd("run enable set", 8'h8e, 16'h2000);
    waitEvent(n);
    waitEvent(n);
    check16("period", 16'(4 * TICKS), 16'(n));
    // Flag lands one clock after the pulse
    @(posedge clk);
    #1;
    checkBit("flag on expiry", 1'b1, timerFlag);
    timerFlagClr = 1'b1;
    @(posedge clk);
    #1 timerFlagClr = 1'b0;
    checkBit("flag cleared", 1'b0, timerFlag);
    host.wr(8'h8e, 16'h0000);
    expectRd("preload preset", TIMER_CONFIG_OFS, 16'hffff);
    host.rd(TIMER_COUNT_OFS, v);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (timerEvent === 1'b1) n++;
    end
    check16("events halted", 16'h0000, 16'(n));
    expectRd("count halted", TIMER_COUNT_OFS, v);
    host.wr(TIMER_CONFIG_OFS, 16'h0005);
    host.wr(8'h8e, 16'h2000);
    waitEvent(n);
    waitEvent(n);
    check16("period restarted", 16'(6 * TICKS), 16'(n));
    // Poll low half until just before its carry into the high half
    n = 0;
    do begin
      host.rd(FREE_RUN_OFS, v);
      n++;
    end while (v < 16'hfffe && n < 40000);
    expectRd("captured high", 8'h9e, 16'h0000);
    host.rd(FREE_RUN_OFS, v);
    checkBit("low wrapped", 1'b1, v < 16'h0010);
    expectRd("high carried", 8'h9e, 16'h0001);
    closeOut;
  end
endmodule
